// file: verilog/mbf_bank.sv
`timescale 1ns/10ps
`include "mbf_map.svh"
module mbf_bank (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Processor ports
    input wire mbf_pkg::mbf_req_s [3:0] req_i,
    // Read answer on memory bus
    output mbf_pkg::mbf_rsp_s rsp_o,
    // Loop-back of the bus as seen by the input receivers
    input wire logic [31:0] loop_data_i,
    input wire logic [3:0] loop_par_i,
    // Status load instruction: strobe, register select
    input wire logic sload_i,
    input wire logic [2:0] sload_sel_i,
    input wire logic [1:0] sload_margin_i,
    output logic [31:0] sload_data_o,
    output logic sload_valid_o,
    // Operational status pins (active high = abnormal)
    input wire logic over_temp_i,
    input wire logic volt_fault_i,
    // Operator panel switches
    input wire logic panel_noilv_i,
    input wire logic panel_margin_en_i,
    input wire logic [1:0] panel_margin_i,
    // Results
    output logic interleave_en_o,
    output logic [1:0] margin_o,
    output logic mem_fault_irq_o
);
    // ******************************
    // Pin inputs synchronised
    // ******************************
    logic temp_s;
    logic volt_s;
    logic noilv_s;
    logic men_s;
    logic [1:0] msw_s;
    mbf_sync3 u_sync_temp (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d_i(over_temp_i), .q_o(temp_s));
    mbf_sync3 u_sync_volt (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d_i(volt_fault_i), .q_o(volt_s));
    mbf_sync3 u_sync_ilv (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d_i(panel_noilv_i), .q_o(noilv_s));
    mbf_sync3 u_sync_men (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .d_i(panel_margin_en_i), .q_o(men_s));
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_msw
            mbf_sync3 u_sync_msw (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
                .d_i(panel_margin_i[g]), .q_o(msw_s[g]));
        end
    endgenerate

    // ******************************
    // Port decode and parity checks
    // ******************************
    logic [3:0] sel_v;
    logic [3:0] aerr_v;
    logic [3:0] derr_v;
    logic [31:0] dperr_v;
    generate
        for (g = 0; g < 4; g++) begin : g_port
            assign sel_v[g] = req_i[g].sel;
            mbf_par_chk #(.W(16)) u_apar (.val_i(req_i[g].addr), .par_i(req_i[g].addr_par),
                .err_o(aerr_v[g]));
            for (genvar b = 0; b < 4; b++) begin : g_byte
                mbf_par_chk #(.W(8)) u_dpar (.val_i(req_i[g].data[8*b +: 8]),
                    .par_i(req_i[g].data_par[b]), .err_o(dperr_v[4*g+b]));
            end
            assign derr_v[g] = |dperr_v[4*g +: 4];
        end
    endgenerate

    // Winning port, conflict detection
    logic conflict;
    logic any_sel;
    logic [1:0] port_idx;
    mbf_pkg::mbf_req_s cur;
    always_comb begin
        any_sel = |sel_v;
        conflict = (sel_v & (sel_v - 4'h1)) != 4'h0;
        port_idx = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (sel_v[i]) begin
                port_idx = 2'(i);
            end
        end
        cur = req_i[port_idx];
    end

    // ******************************
    // Core storage with byte parity
    // ******************************
    logic [35:0] core_mem [0:`MBF_DEPTH-1];
    logic [35:0] core_rd_reg;
    logic rd_pend_reg;
    logic rd_pend_next;
    logic do_acc;
    logic [3:0] wpar;
    logic [`MBF_IDX_W-1:0] cidx;
    // Access decision, core index and parity of the stored word
    always_comb begin
        // conflict or bad parity abandons access
        do_acc = any_sel & ~conflict & ~aerr_v[port_idx] & ~(cur.wr & derr_v[port_idx]);
        // Interleaved: low address bits pick word; off: upper bits
        cidx = noilv_s ? cur.addr[15:8] : cur.addr[7:0];
        rd_pend_next = do_acc & ~cur.wr;
        // generate odd parity for stored byte
        for (int b = 0; b < 4; b++) begin
            wpar[b] = ~(^cur.data[8*b +: 8]);
        end
    end
    // Core write and read port, no reset on the array
    always_ff @(posedge ref_clk_i) begin
        if (do_acc && cur.wr) begin
            core_mem[cidx] <= {wpar, cur.data};
        end
        if (do_acc && !cur.wr) begin
            core_rd_reg <= core_mem[cidx];
        end
    end

    // ******************************
    // Read path, loop-back check
    // ******************************
    logic [3:0] cerr_v;
    logic core_err;
    logic [3:0] lerr_v;
    logic loop_err;
    logic [31:0] loop_reg;
    logic [3:0] loopp_reg;
    logic loop_vld_reg;
    mbf_pkg::mbf_rsp_s rsp_reg;
    mbf_pkg::mbf_rsp_s rsp_next;
    generate
        for (g = 0; g < 4; g++) begin : g_rbyte
            mbf_par_chk #(.W(8)) u_cpar (.val_i(core_rd_reg[8*g +: 8]),
                .par_i(core_rd_reg[32+g]), .err_o(cerr_v[g]));
            mbf_par_chk #(.W(8)) u_lpar (.val_i(loop_reg[8*g +: 8]),
                .par_i(loopp_reg[g]), .err_o(lerr_v[g]));
        end
    endgenerate
    // Fault flags of the read path and next bus word
    always_comb begin
        core_err = rd_pend_reg & (|cerr_v);
        loop_err = loop_vld_reg & (|lerr_v);
        rsp_next.valid = rd_pend_reg;
        rsp_next.data = rd_pend_reg ? core_rd_reg[31:0] : 32'h0000_0000;
        rsp_next.data_par = rd_pend_reg ? core_rd_reg[35:32] : 4'h0;
    end
    // Register the read pipeline and the looped bus
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_pend_reg <= 1'b0;
            rsp_reg <= '0;
            loop_vld_reg <= 1'b0;
            loop_reg <= 32'h0000_0000;
            loopp_reg <= 4'h0;
        end else begin
            rd_pend_reg <= rd_pend_next;
            rsp_reg <= rsp_next;
            loop_vld_reg <= rsp_reg.valid;
            loop_reg <= loop_data_i;
            loopp_reg <= loop_par_i;
        end
    end

    // ******************************
    // Snapshot capture
    // ******************************
    logic [5:0] kind;
    logic fault;
    mbf_pkg::mbf_snap_e st_reg;
    mbf_pkg::mbf_snap_e st_next;
    logic [31:0] snap_reg [0:3];
    logic [31:0] snap_next [0:3];
    logic [1:0] margin_reg;
    logic [1:0] margin_next;
    logic [31:0] sdata_reg;
    logic [31:0] sdata_next;
    logic svld_reg;
    logic irq_reg;
    logic irq_next;
    logic ilv_reg;
    logic capture; // Take a new snapshot this cycle
    // Fault kind, snapshot, readout and margin next values
    always_comb begin
        kind = 6'h00;
        kind[`MBF_K_CORE] = core_err;
        kind[`MBF_K_ADDR] = any_sel & ~conflict & aerr_v[port_idx];
        kind[`MBF_K_WDATA] = any_sel & ~conflict & cur.wr & derr_v[port_idx];
        kind[`MBF_K_CONFLICT] = conflict;
        kind[`MBF_K_STATUS] = temp_s | volt_s;
        kind[`MBF_K_LOOP] = loop_err;
        fault = |kind;
        st_next = st_reg;
        irq_next = irq_reg;
        for (int i = 0; i < 4; i++) begin
            snap_next[i] = snap_reg[i];
        end
        sdata_next = 32'h0000_0000;
        capture = 1'b0;
        case (st_reg)
            mbf_pkg::MBF_ARMED: begin
                // only the first fault is taken
                capture = fault;
            end
            mbf_pkg::MBF_HELD: begin
                if (sload_i && sload_sel_i == {1'b0, `MBF_SNAP_KIND}) begin
                    st_next = mbf_pkg::MBF_ARMED;
                    irq_next = 1'b0;
                    // A fault in the rearm cycle wins over the clear
                    capture = fault;
                end
            end
            default: begin
                st_next = mbf_pkg::MBF_ARMED;
            end
        endcase
        if (capture) begin
            snap_next[`MBF_SNAP_KIND] = {16'h0000, margin_reg, ~ilv_reg, cur.wr,
                2'b00, port_idx, 2'b00, kind};
            snap_next[`MBF_SNAP_ADDR] = {15'h0000, cur.addr_par, cur.addr};
            snap_next[`MBF_SNAP_DATA] = core_err ? core_rd_reg[31:0] :
                (loop_err ? loop_reg : cur.data);
            snap_next[`MBF_SNAP_STAT] = {16'h0000, sel_v, cur.data_par,
                lerr_v, cerr_v};
            st_next = mbf_pkg::MBF_HELD;
            irq_next = 1'b1;
        end
        if (sload_i && !sload_sel_i[2]) begin
            sdata_next = snap_reg[sload_sel_i[1:0]];
        end
        // margin: panel switches override coded load
        margin_next = margin_reg;
        if (men_s) begin
            margin_next = msw_s;
        end else if (sload_i && sload_sel_i == `MBF_SEL_MARGIN) begin
            margin_next = sload_margin_i;
        end
    end
    // Register snapshot state, readout and panel results
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_reg <= mbf_pkg::MBF_ARMED;
            irq_reg <= 1'b0;
            svld_reg <= 1'b0;
            sdata_reg <= 32'h0000_0000;
            margin_reg <= `MBF_MARGIN_RST;
            ilv_reg <= 1'b1;
            for (int i = 0; i < 4; i++) begin
                snap_reg[i] <= 32'h0000_0000;
            end
        end else begin
            st_reg <= st_next;
            irq_reg <= irq_next;
            svld_reg <= sload_i;
            sdata_reg <= sdata_next;
            margin_reg <= margin_next;
            ilv_reg <= ~noilv_s;
            for (int i = 0; i < 4; i++) begin
                snap_reg[i] <= snap_next[i];
            end
        end
    end

    // Outputs straight from flip-flops
    assign rsp_o = rsp_reg;
    assign sload_data_o = sdata_reg;
    assign sload_valid_o = svld_reg;
    assign margin_o = margin_reg;
    assign interleave_en_o = ilv_reg;
    assign mem_fault_irq_o = irq_reg;
endmodule : mbf_bank

// file: pkg/mbf_map.svh
`ifndef MBF_MAP_SVH
`define MBF_MAP_SVH
// Widths
`define MBF_DATA_W 32
`define MBF_ADDR_W 16
`define MBF_PORTS 4
`define MBF_DEPTH 256
`define MBF_IDX_W 8
// Snap register 0 field positions (fault kind bits)
`define MBF_K_CORE 0
`define MBF_K_ADDR 1
`define MBF_K_WDATA 2
`define MBF_K_CONFLICT 3
`define MBF_K_STATUS 4
`define MBF_K_LOOP 5
`define MBF_K_PORT_LO 8
`define MBF_K_WRITE 12
`define MBF_K_NOILV 13
`define MBF_K_MARGIN_LO 14
// Snap register selectors
`define MBF_SNAP_KIND 2'h0
`define MBF_SNAP_ADDR 2'h1
`define MBF_SNAP_DATA 2'h2
`define MBF_SNAP_STAT 2'h3
// Special coded status load: selector value that writes the margin
`define MBF_SEL_MARGIN 3'h4
// Reset values
`define MBF_MARGIN_RST 2'h0
`endif

// file: pkg/mbf_pkg.sv
package mbf_pkg;
    // Clock margin setting
    typedef enum logic [1:0] {
        MBF_MARGIN_NORMAL = 2'b00,
        MBF_MARGIN_FAST = 2'b01,
        MBF_MARGIN_SLOW = 2'b10
    } mbf_margin_e;
    // Snapshot state
    typedef enum logic [0:0] {
        MBF_ARMED = 1'b0,
        MBF_HELD = 1'b1
    } mbf_snap_e;
    // One processor port request
    typedef struct packed {
        logic sel;
        logic wr;
        logic [15:0] addr;
        logic addr_par;
        logic [31:0] data;
        logic [3:0] data_par;
    } mbf_req_s;
    // Read answer towards processors
    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic [3:0] data_par;
    } mbf_rsp_s;
endpackage : mbf_pkg

// file: verilog/mbf_par_chk.sv
`timescale 1ns/10ps
// Odd parity check over one field
module mbf_par_chk #(
    parameter int W = 8
) (
    // Field and its parity bit
    input wire logic [W-1:0] val_i,
    input wire logic par_i,
    // High on mismatch
    output logic err_o
);
    // Odd parity: total of ones incl. parity bit must be odd
    always_comb begin
        err_o = ~(^{val_i, par_i});
    end
endmodule : mbf_par_chk

// file: verilog/mbf_sync3.sv
`timescale 1ns/10ps
`include "mbf_map.svh"
// Three-stage synchroniser, output changes when stages two and three agree
module mbf_sync3 (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Asynchronous level in, filtered level out
    input wire logic d_i,
    output logic q_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic q_reg;
    logic q_next;
    // Accept a change once the two later stages agree
    always_comb begin
        q_next = q_reg;
        if (s2_reg == s3_reg) begin
            q_next = s3_reg;
        end
    end
    // Register stages
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_reg <= 1'b0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end
    assign q_o = q_reg;
endmodule : mbf_sync3

// file: bench/mbf_proc_model.sv
`timescale 1ns/10ps
// Processor port: sends requests with parity, checks the returned word
module mbf_proc_model (
    // Request fields from the bench
    input wire logic sel_i,
    input wire logic wr_i,
    input wire logic [15:0] addr_i,
    input wire logic [31:0] data_i,
    input wire logic [1:0] flip_i,
    output mbf_pkg::mbf_req_s req_o,
    // Answer from the bank
    input wire mbf_pkg::mbf_rsp_s rsp_i,
    output logic rsp_bad_o
);
    // odd parity out, unselected lines inverted, flip spoils parity
    always_comb begin
        req_o.sel = sel_i;
        req_o.wr = wr_i;
        req_o.addr = sel_i ? addr_i : ~addr_i;
        req_o.data = sel_i ? data_i : ~data_i;
        req_o.addr_par = ~^req_o.addr ^ flip_i[0];
        rsp_bad_o = 1'b0;
        for (int b = 0; b < 4; b++) begin
            req_o.data_par[b] = ~^req_o.data[8*b+:8] ^ flip_i[1];
            rsp_bad_o = rsp_bad_o | (rsp_i.valid & ~^{rsp_i.data[8*b+:8], rsp_i.data_par[b]});
        end
    end
endmodule : mbf_proc_model

// file: bench/mbf_monitor.sv
`timescale 1ns/10ps
// Port-level checks of the fault snapshot bank
module mbf_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire mbf_pkg::mbf_req_s [3:0] req_i,
    input wire mbf_pkg::mbf_rsp_s rsp_o,
    input wire logic sload_i,
    input wire logic [2:0] sload_sel_i,
    input wire logic sload_valid_o,
    input wire logic interleave_en_o,
    input wire logic [1:0] margin_o,
    input wire logic mem_fault_irq_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Selected count, request parity faults, selected write request, answer parity
    logic [2:0] nsel;
    logic bad_a, bad_d, any_wr, rsp_ok;
    always_comb begin
        nsel = 3'h0;
        bad_a = 1'b0;
        bad_d = 1'b0;
        any_wr = 1'b0;
        rsp_ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            nsel = nsel + 3'(req_i[i].sel);
            any_wr = any_wr | (req_i[i].sel & req_i[i].wr);
            bad_a = bad_a | (req_i[i].sel & ~^{req_i[i].addr, req_i[i].addr_par});
            for (int b = 0; b < 4; b++) begin
                bad_d = bad_d | (req_i[i].sel & req_i[i].wr
                    & ~^{req_i[i].data[8*b+:8], req_i[i].data_par[b]});
            end
            rsp_ok = rsp_ok & ^{rsp_o.data[8*i+:8], rsp_o.data_par[i]};
        end
    end
    // Clean single-port read
    sequence s_good_read;
        nsel == 3'h1 && !bad_a && !any_wr;
    endsequence
    chk_reset_vals: assert property (disable iff (1'b0) rst_i |=> interleave_en_o
        && !mem_fault_irq_o && margin_o == 2'h0) else $error("bad reset outputs");
    chk_sload_answer: assert property (sload_i |=> sload_valid_o)
        else $error("status load not answered");
    chk_sload_pulse: assert property (!sload_i |=> !sload_valid_o)
        else $error("status valid without load");
    chk_read_latency: assert property (s_good_read |-> ##2 rsp_o.valid)
        else $error("read answer missing");
    chk_abandon_rsp: assert property (nsel != 3'h1 |-> ##2 !rsp_o.valid)
        else $error("answer without single select");
    chk_rsp_parity: assert property (rsp_o.valid |-> rsp_ok)
        else $error("answer parity wrong");
    chk_conflict_irq: assert property (nsel > 3'h1 && !mem_fault_irq_o |=> mem_fault_irq_o)
        else $error("conflict not flagged");
    chk_req_par_irq: assert property (nsel == 3'h1 && (bad_a || bad_d) && !mem_fault_irq_o
        |=> mem_fault_irq_o) else $error("request parity not flagged");
    chk_irq_holds: assert property (mem_fault_irq_o && !(sload_i && sload_sel_i == 3'h0)
        |=> mem_fault_irq_o) else $error("fault dropped before read");
endmodule : mbf_monitor

// file: bench/mbf_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] p_sel = 4'h0;
    logic [3:0] p_wr = 4'h0;
    logic [15:0] p_addr [4] = '{default: 16'h0000};
    logic [31:0] p_data [4] = '{default: 32'h0000_0000};
    logic [1:0] p_flip [4] = '{default: 2'h0};
    logic [3:0] loop_inj = 4'h0;
    logic sload_i = 1'b0;
    logic [2:0] sload_sel_i = 3'h0;
    logic [1:0] sload_margin_i = 2'h0;
    logic [3:0] stat = 4'h0;
    logic [1:0] panel_margin_i = 2'h0;
    wire mbf_pkg::mbf_req_s [3:0] req;
    wire [3:0] rsp_bad;
    mbf_pkg::mbf_rsp_s rsp;
    logic [31:0] sload_data_o;
    logic sload_valid_o;
    logic interleave_en_o;
    logic mem_fault_irq_o;
    logic [1:0] margin_o;
    logic [31:0] v;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    for (genvar g = 0; g < 4; g++) begin : g_proc
        mbf_proc_model i_proc (.sel_i(p_sel[g]), .wr_i(p_wr[g]), .addr_i(p_addr[g]),
            .data_i(p_data[g]), .flip_i(p_flip[g]), .req_o(req[g]), .rsp_i(rsp),
            .rsp_bad_o(rsp_bad[g]));
    end
    mbf_bank i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp),
        .loop_data_i(rsp.data), .loop_par_i(rsp.data_par ^ loop_inj), .sload_i(sload_i),
        .sload_sel_i(sload_sel_i), .sload_margin_i(sload_margin_i),
        .sload_data_o(sload_data_o), .sload_valid_o(sload_valid_o),
        .over_temp_i(stat[0]), .volt_fault_i(stat[1]), .panel_noilv_i(stat[2]),
        .panel_margin_en_i(stat[3]), .panel_margin_i(panel_margin_i),
        .interleave_en_o(interleave_en_o), .margin_o(margin_o),
        .mem_fault_irq_o(mem_fault_irq_o));
    initial forever #4 ref_clk_i = ~ref_clk_i;
    // Hang guard
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // One access; port i sends d ^ i; returns at the taking edge
    task automatic acc(input logic [3:0] m, input logic w, input logic [15:0] a,
        input logic [31:0] d, input logic [1:0] f);
        @(posedge ref_clk_i);
        p_sel <= m;
        p_wr <= {4{w}};
        for (int i = 0; i < 4; i++) begin
            p_addr[i] <= a;
            p_data[i] <= d ^ i;
            p_flip[i] <= f;
        end
        @(posedge ref_clk_i);
        p_sel <= 4'h0;
    endtask : acc
    // Status load of one selector
    task automatic snap(input logic [2:0] s, output logic [31:0] r);
        @(posedge ref_clk_i);
        sload_i <= 1'b1;
        sload_sel_i <= s;
        @(posedge ref_clk_i);
        sload_i <= 1'b0;
        #1 `CHK("sload_valid", 1'b1, sload_valid_o)
        r = sload_data_o;
    endtask : snap
    task automatic irq_next(input logic e);
        @(posedge ref_clk_i);
        #1 `CHK("irq", e, mem_fault_irq_o)
    endtask : irq_next
    // Fault kind read and rearm
    task automatic kind_is(input logic [15:0] e);
        snap(3'h0, v);
        `CHK("snap_kind", {16'h0000, e}, v)
        `CHK("irq_rearm", 1'b0, mem_fault_irq_o)
        $display("fault case done");
    endtask : kind_is
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 `CHK("rst_ilv", 1'b1, interleave_en_o)
        `CHK("rst_irq", 1'b0, mem_fault_irq_o)
        acc(4'h4, 1'b1, 16'h0012, 32'hA5C3_0F01, 2'h0);
        acc(4'h4, 1'b0, 16'h0012, 32'h0000_0000, 2'h0);
        @(posedge ref_clk_i);
        #1 `CHK("rd_data", 32'hA5C3_0F03, rsp.data)
        `CHK("rd_par", 4'h0, rsp_bad)
        `CHK("rd_irq", 1'b0, mem_fault_irq_o)
        $display("read write done");
        acc(4'h2, 1'b0, 16'h0034, 32'h0000_0000, 2'h1);
        irq_next(1'b1);
        acc(4'h3, 1'b1, 16'h0012, 32'h0000_0000, 2'h0);
        snap(3'h1, v);
        `CHK("snap_addr", 32'h0001_0034, v)
        kind_is(16'h0102);
        acc(4'h9, 1'b1, 16'h0012, 32'h1111_2222, 2'h0);
        irq_next(1'b1);
        kind_is(16'h1008);
        acc(4'h1, 1'b1, 16'h0012, 32'h3333_4444, 2'h2);
        irq_next(1'b1);
        snap(3'h2, v);
        `CHK("snap_data", 32'h3333_4444, v)
        kind_is(16'h1004);
        @(posedge ref_clk_i);
        loop_inj <= 4'h2;
        acc(4'h1, 1'b0, 16'h0012, 32'h0000_0000, 2'h0);
        @(posedge ref_clk_i);
        #1 `CHK("keep_data", 32'hA5C3_0F03, rsp.data)
        repeat (2) @(posedge ref_clk_i);
        #1 `CHK("loop_irq", 1'b1, mem_fault_irq_o)
        @(posedge ref_clk_i);
        loop_inj <= 4'h0;
        kind_is(16'h0020);
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk_i);
            stat[k] <= 1'b1;
            for (int i = 0; i < 12 && mem_fault_irq_o !== 1'b1; i++) @(posedge ref_clk_i);
            #1 `CHK("stat_irq", 1'b1, mem_fault_irq_o)
            @(posedge ref_clk_i);
            stat[k] <= 1'b0;
            repeat (8) @(posedge ref_clk_i);
            kind_is(16'h0010);
        end
        @(posedge ref_clk_i);
        stat[2] <= 1'b1;
        sload_margin_i <= 2'h2;
        repeat (8) @(posedge ref_clk_i);
        #1 `CHK("ilv_off", 1'b0, interleave_en_o)
        acc(4'h1, 1'b1, 16'h5600, 32'h1234_5678, 2'h0);
        snap(3'h4, v);
        `CHK("margin_ld", 32'h0000_0000, v)
        @(posedge ref_clk_i);
        #1 `CHK("margin_code", 2'h2, margin_o)
        @(posedge ref_clk_i);
        stat <= 4'h8;
        panel_margin_i <= 2'h1;
        repeat (8) @(posedge ref_clk_i);
        #1 `CHK("margin_panel", 2'h1, margin_o)
        `CHK("ilv_on", 1'b1, interleave_en_o)
        snap(3'h4, v);
        @(posedge ref_clk_i);
        #1 `CHK("margin_keep", 2'h1, margin_o)
        acc(4'h1, 1'b0, 16'h0056, 32'h0000_0000, 2'h0);
        @(posedge ref_clk_i);
        #1 `CHK("ilv_map", 32'h1234_5678, rsp.data)
        $display("panel done");
        print_verdict();
    end
endmodule : tb
bind mbf_bank mbf_monitor i_mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
    .rsp_o(rsp_o), .sload_i(sload_i), .sload_sel_i(sload_sel_i),
    .sload_valid_o(sload_valid_o), .interleave_en_o(interleave_en_o),
    .margin_o(margin_o), .mem_fault_irq_o(mem_fault_irq_o));
